/* core/scm_pkg.sv */
// constants and types for the smartcard mode and routing controller
// assumes a 25 MHz core clock and a host reaching the registers over i2c
package scm_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SLOT_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CLK_BASE  = 8'h02;
  localparam logic [7:0] ADDR_SYNC_SET  = 8'h09;
  localparam logic [7:0] ADDR_MOD_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h40;
  localparam logic [7:0] ADDR_DEV_SET   = 8'h42;
  localparam logic [7:0] ADDR_GPIO_STAT = 8'h43;
  // field positions
  localparam int SS_CARD_TYPE   = 7;
  localparam int SS_ACT_TYPE    = 6;
  localparam int SS_AUX_A       = 5;
  localparam int SS_AUX_B       = 4;
  localparam int SS_START       = 0;
  localparam int SC_START_ASYNC = 0;
  localparam int SC_IO_EN       = 5;
  localparam int CK_SRC         = 0;
  localparam int CK_DIV_LSB     = 1;
  localparam int CK_DIV_W       = 2;
  localparam int MC_ACT_LSB     = 0;
  localparam int MC_SEL_LSB     = 4;
  localparam int MC_SEL_W       = 2;
  localparam int DS_OUT_LSB     = 4;
  localparam int GS_FLAG_LSB    = 4;
  localparam int ST_CARD_PRESENCE_INPUT        = 0;
  localparam int ST_MODE_LSB    = 1;
  localparam int BYTE_MSB       = 7;
  // reset values
  localparam logic [7:0] RST_SLOT_CTRL = 8'h00;
  localparam logic [7:0] RST_CLK_CFG   = 8'h00;
  localparam logic [7:0] RST_SYNC_SET  = 8'h30;
  localparam logic [7:0] RST_MOD_CTRL  = 8'h00;
  localparam logic [7:0] RST_DEV_SET   = 8'h0f;
  // timing
  localparam int CLK_HZ            = 25_000_000;
  localparam int GPIO_MIN_PULSE_NS = 10_000;
  localparam int GPIO_MIN_PULSE_CYC = (GPIO_MIN_PULSE_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int SYNC_STAGES       = 3;
  localparam logic [2:0] IO_HOLD   = 3'h4;
  localparam logic [3:0] I2C_BITS  = 4'h8;
  // device modes and user slot operating modes
  typedef enum logic [1:0] {SCM_OFF, SCM_SHUTDOWN, SCM_STANDBY, SCM_ACTIVE} scm_mode_t;
  typedef enum logic [1:0] {SCM_UOP_ASYNC, SCM_UOP_SYNC1, SCM_UOP_SYNC2, SCM_UOP_MANUAL} scm_uop_t;
endpackage

/* core/scm_reg_if.sv */
// register access path between the i2c engine and the register file
// assumes both ends share clk
`timescale 1ns/100ps
interface scm_reg_if;
  logic       en;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (input en, input rdata, output wr_stb, output addr, output wdata);
  modport regs  (output en, output rdata, input wr_stb, input addr, input wdata);
endinterface

/* core/scm_i2c_slave.sv */
// i2c target: pointer byte then data bytes, auto increment on read and write
// assumes scl and sda already synchronised to clk
`timescale 1ns/100ps
module scm_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // synchronised bus lines
  input  wire logic scl_s,
  input  wire logic sda_s,
  output wire logic sda_drive,
  // register access
  scm_reg_if.slave  rif
);
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK_A, I_WR, I_ACK_W, I_RD, I_ACK_R} scm_i2c_st_t;

  scm_i2c_st_t st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic [7:0]  wdata_r;
  logic        first_r;
  logic        rw_r;
  logic        nack_r;
  logic        drv_r;
  logic        wr_stb_r;
  logic        scl_q;
  logic        sda_q;
  logic [6:0]  sh_addr;
  logic        sh_rw;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;

  assign {sh_addr, sh_rw} = sh_r;
  assign rise  = scl_s & ~scl_q;
  assign fall  = ~scl_s & scl_q;
  assign start = scl_s & scl_q & sda_q & ~sda_s;
  assign stop  = scl_s & scl_q & ~sda_q & sda_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= I_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= 8'h00;
      wdata_r  <= 8'h00;
      first_r  <= 1'b0;
      rw_r     <= 1'b0;
      nack_r   <= 1'b0;
      drv_r    <= 1'b0;
      wr_stb_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (wr_stb_r) begin
        ptr_r <= ptr_r + 8'h01;
      end
      if (!rif.en) begin
        st_r  <= I_IDLE;
        drv_r <= 1'b0;
      end else if (start) begin
        st_r    <= I_ADDR;
        cnt_r   <= 4'h0;
        first_r <= 1'b1;
        drv_r   <= 1'b0;
      end else if (stop) begin
        st_r  <= I_IDLE;
        drv_r <= 1'b0;
      end else if (rise) begin
        cnt_r  <= cnt_r + 4'h1;
        sh_r   <= {sh_r[scm_pkg::BYTE_MSB-1:0], sda_s};
        nack_r <= sda_s;
      end else if (fall) begin
        case (st_r)
          I_ADDR: begin
            if (cnt_r == scm_pkg::I2C_BITS) begin
              cnt_r <= 4'h0;
              if (sh_addr == DEV_ADDR) begin
                st_r  <= I_ACK_A;
                rw_r  <= sh_rw;
                drv_r <= 1'b1;
              end else begin
                st_r <= I_IDLE;
              end
            end
          end
          I_ACK_A: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              st_r  <= I_RD;
              tx_r  <= rif.rdata;
              drv_r <= ~rif.rdata[scm_pkg::BYTE_MSB];
            end else begin
              st_r  <= I_WR;
              drv_r <= 1'b0;
            end
          end
          I_WR: begin
            if (cnt_r == scm_pkg::I2C_BITS) begin
              cnt_r <= 4'h0;
              st_r  <= I_ACK_W;
              drv_r <= 1'b1;
              if (first_r) begin
                ptr_r   <= sh_r;
                first_r <= 1'b0;
              end else begin
                wr_stb_r <= 1'b1;
                wdata_r  <= sh_r;
              end
            end
          end
          I_ACK_W: begin
            cnt_r <= 4'h0;
            st_r  <= I_WR;
            drv_r <= 1'b0;
          end
          I_RD: begin
            if (cnt_r == scm_pkg::I2C_BITS) begin
              st_r  <= I_ACK_R;
              drv_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
            end else begin
              tx_r  <= tx_r << 1;
              drv_r <= ~tx_r[scm_pkg::BYTE_MSB-1];
            end
          end
          I_ACK_R: begin
            cnt_r <= 4'h0;
            if (nack_r) begin
              st_r  <= I_IDLE;
              drv_r <= 1'b0;
            end else begin
              st_r  <= I_RD;
              tx_r  <= rif.rdata;
              drv_r <= ~rif.rdata[scm_pkg::BYTE_MSB];
            end
          end
          default: begin
            drv_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign rif.wr_stb = wr_stb_r;
  assign rif.addr   = ptr_r;
  assign rif.wdata  = wdata_r;
  assign sda_drive  = drv_r;
endmodule

/* core/scm_top.sv */
// mode control, register file, clock dividers, io muxes, aux lines and gpios
// assumes all pin inputs asynchronous to clk; pins resolved outside from out and oe_n
`timescale 1ns/100ps
module scm_top #(
  parameter logic [6:0] I2C_ADDR = 7'h2a,
  parameter int         OSC_DIV  = 4,
  parameter int         NMOD     = 3,
  parameter int         NGPIO    = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // supply monitors and low-power request
  input  wire logic             vdd_ok,
  input  wire logic             vddi_ok,
  input  wire logic             low_power_request_pin,
  // i2c
  input  wire logic             scl,
  input  wire logic             sda_in,
  output wire logic             sda_out,
  output wire logic             sda_oe_n,
  // user card slot
  input  wire logic             card_presence_input,
  input  wire logic             user_clock_source,
  output wire logic             user_card_clock,
  input  wire logic             user_card_io_in,
  output wire logic             user_card_io_out,
  output wire logic             user_card_io_oe_n,
  input  wire logic             aux_line_a_in,
  output wire logic             aux_line_a_out,
  output wire logic             aux_line_a_oe_n,
  input  wire logic             aux_line_b_in,
  output wire logic             aux_line_b_out,
  output wire logic             aux_line_b_oe_n,
  output scm_pkg::scm_uop_t     user_card_mode,
  // secure module slots
  input  wire logic             module_clock_source,
  output wire logic [NMOD-1:0]  module_clock,
  input  wire logic [NMOD-1:0]  module_io_in,
  output wire logic [NMOD-1:0]  module_io_out,
  output wire logic [NMOD-1:0]  module_io_oe_n,
  // host io
  input  wire logic             host_io_user_in,
  output wire logic             host_io_user_out,
  output wire logic             host_io_user_oe_n,
  input  wire logic             host_io_modules_in,
  output wire logic             host_io_modules_out,
  output wire logic             host_io_modules_oe_n,
  // gpio and interrupt
  input  wire logic [NGPIO-1:0] gpio_in,
  output wire logic [NGPIO-1:0] gpio_out,
  output wire logic [NGPIO-1:0] gpio_oe_n,
  output wire logic             int_n,
  // status
  output wire logic [NMOD:0]    slot_active,
  output scm_pkg::scm_mode_t    mode
);
  localparam int NIN = 13 + NMOD + NGPIO;
  localparam int NCH = NMOD + 1;

  if (OSC_DIV < 1) begin : g_chk_osc
    $error("OSC_DIV must be at least one");
  end
  if (NMOD != 3 || NGPIO != 4) begin : g_chk_cnt
    $error("register layout serves three module slots and four gpios");
  end
  if (scm_pkg::GPIO_MIN_PULSE_CYC <= scm_pkg::SYNC_STAGES + 1) begin : g_chk_pulse
    $error("clock too slow for the gpio minimum pulse");
  end

  // input synchronisers
  logic [NIN-1:0]   raw;
  logic [NIN-1:0]   s1;
  logic [NIN-1:0]   s2;
  logic [NIN-1:0]   s3;
  logic [NIN-1:0]   stab;
  logic             vdd_s;
  logic             vddi_s;
  logic             lp_s;
  logic             scl_s;
  logic             sda_s;
  logic             card_presence_input_s;
  logic             ucs_s;
  logic             mcs_s;
  logic             ucio_s;
  logic             aa_s;
  logic             ab_s;
  logic [NMOD-1:0]  mio_s;
  logic             hu_s;
  logic             hm_s;
  logic [NGPIO-1:0] gpio_s;

  assign raw = {vdd_ok, vddi_ok, low_power_request_pin, scl, sda_in, card_presence_input,
                user_clock_source, module_clock_source, user_card_io_in, aux_line_a_in,
                aux_line_b_in, module_io_in, host_io_user_in, host_io_modules_in, gpio_in};
  assign {vdd_s, vddi_s, lp_s, scl_s, sda_s, card_presence_input_s, ucs_s, mcs_s, ucio_s, aa_s, ab_s,
          mio_s, hu_s, hm_s, gpio_s} = stab;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      stab <= '0;
    end else begin
      s1   <= raw;
      s2   <= s1;
      s3   <= s2;
      stab <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stab);
    end
  end

  // registers
  logic [7:0]       slot_ctrl_r;
  logic [7:0]       sync_set_r;
  logic [7:0]       mod_ctrl_r;
  logic [7:0]       dev_set_r;
  logic [7:0]       clk_cfg_r [NCH];
  logic [NGPIO-1:0] gflag_r;
  logic [NGPIO-1:0] glast_r;
  logic             int_n_r;
  logic             uact_q;
  logic             aux_a_oe_n_r;
  logic             aux_b_oe_n_r;
  logic [7:0]       rd;
  logic             user_act;
  logic [NMOD-1:0]  mod_act;
  logic [NCH-1:0]   act;
  logic             quiet;
  logic             run;
  logic             sda_drive;
  scm_pkg::scm_mode_t mode_r;
  scm_pkg::scm_mode_t mode_nxt;
  scm_pkg::scm_uop_t  uop_r;
  scm_reg_if          rif ();

  assign user_act = slot_ctrl_r[scm_pkg::SC_START_ASYNC] | sync_set_r[scm_pkg::SS_START];
  assign mod_act  = mod_ctrl_r[scm_pkg::MC_ACT_LSB +: NMOD];
  assign act      = {mod_act, user_act};
  assign run      = (mode_r == scm_pkg::SCM_STANDBY) || (mode_r == scm_pkg::SCM_ACTIVE);
  assign quiet    = (mode_nxt == scm_pkg::SCM_OFF) || (mode_nxt == scm_pkg::SCM_SHUTDOWN);

  // mode controller
  always_comb begin
    if (!vdd_s || !vddi_s) begin
      mode_nxt = scm_pkg::SCM_OFF;
    end else if (!lp_s) begin
      mode_nxt = scm_pkg::SCM_SHUTDOWN;
    end else if (|act && run) begin
      mode_nxt = scm_pkg::SCM_ACTIVE;
    end else begin
      mode_nxt = scm_pkg::SCM_STANDBY;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= scm_pkg::SCM_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // i2c engine, silent unless standby or active
  assign rif.en = run;

  scm_i2c_slave #(
    .DEV_ADDR (I2C_ADDR)
  ) u_i2c (
    .clk       (clk),
    .rstn      (rstn),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .sda_drive (sda_drive),
    .rif       (rif.slave)
  );

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_drive;

  // register writes; shutdown and power-off clear every activation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_ctrl_r <= scm_pkg::RST_SLOT_CTRL;
      sync_set_r  <= scm_pkg::RST_SYNC_SET;
      mod_ctrl_r  <= scm_pkg::RST_MOD_CTRL;
      dev_set_r   <= scm_pkg::RST_DEV_SET;
    end else begin
      if (rif.wr_stb) begin
        case (rif.addr)
          scm_pkg::ADDR_SLOT_CTRL: slot_ctrl_r <= rif.wdata;
          scm_pkg::ADDR_SYNC_SET:  sync_set_r  <= rif.wdata;
          scm_pkg::ADDR_MOD_CTRL:  mod_ctrl_r  <= rif.wdata;
          scm_pkg::ADDR_DEV_SET:   dev_set_r   <= rif.wdata;
          default: ;
        endcase
      end
      if (quiet) begin
        slot_ctrl_r[scm_pkg::SC_START_ASYNC]     <= 1'b0;
        sync_set_r[scm_pkg::SS_START]            <= 1'b0;
        mod_ctrl_r[scm_pkg::MC_ACT_LSB +: NMOD]  <= '0;
      end
    end
  end

  // user slot operating mode, frozen while the slot is active
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uact_q <= 1'b0;
      uop_r  <= scm_pkg::SCM_UOP_ASYNC;
    end else begin
      uact_q <= user_act;
      if (user_act && !uact_q) begin
        if (!sync_set_r[scm_pkg::SS_START]) begin
          uop_r <= scm_pkg::SCM_UOP_ASYNC;
        end else if (!sync_set_r[scm_pkg::SS_ACT_TYPE]) begin
          uop_r <= scm_pkg::SCM_UOP_MANUAL;
        end else if (sync_set_r[scm_pkg::SS_CARD_TYPE]) begin
          uop_r <= scm_pkg::SCM_UOP_SYNC2;
        end else begin
          uop_r <= scm_pkg::SCM_UOP_SYNC1;
        end
      end
    end
  end

  // aux open-drain lines: low while idle, bit-controlled while active
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_a_oe_n_r <= 1'b0;
      aux_b_oe_n_r <= 1'b0;
    end else begin
      aux_a_oe_n_r <= user_act & sync_set_r[scm_pkg::SS_AUX_A];
      aux_b_oe_n_r <= user_act & sync_set_r[scm_pkg::SS_AUX_B];
    end
  end

  // gpio change flags, write one to clear, set wins
  logic [NGPIO-1:0] gdir;
  logic [NGPIO-1:0] gset;
  logic [NGPIO-1:0] gclr;
  logic [NGPIO-1:0] gflag_nxt;
  assign gdir      = dev_set_r[NGPIO-1:0];
  assign gset      = {NGPIO{run}} & gdir & (gpio_s ^ glast_r);
  assign gclr      = (rif.wr_stb && rif.addr == scm_pkg::ADDR_GPIO_STAT) ?
                     rif.wdata[scm_pkg::GS_FLAG_LSB +: NGPIO] : '0;
  assign gflag_nxt = (gflag_r & ~gclr) | gset;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      glast_r <= '0;
      gflag_r <= '0;
      int_n_r <= 1'b1;
    end else begin
      glast_r <= gpio_s;
      gflag_r <= gflag_nxt;
      int_n_r <= ~|gflag_nxt;
    end
  end

  assign gpio_out  = '0;
  assign gpio_oe_n = ~({NGPIO{run}} & ~gdir & ~dev_set_r[scm_pkg::DS_OUT_LSB +: NGPIO]);
  assign int_n     = int_n_r;

  // slot clocks from external source or oscillator through a divider
  logic [$clog2(OSC_DIV+1)-1:0] osc_cnt_r;
  logic                         osc_tick;
  logic [NCH-1:0]               ck_r;
  assign osc_tick = (osc_cnt_r == ($clog2(OSC_DIV+1))'(OSC_DIV - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_tick ? '0 : osc_cnt_r + 1'b1;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_clk
    logic       src_s;
    logic       src_q;
    logic       tick;
    logic [2:0] cnt_r;
    logic [2:0] lim;
    assign src_s = (i == 0) ? ucs_s : mcs_s;
    assign tick  = clk_cfg_r[i][scm_pkg::CK_SRC] ? osc_tick : (src_s & ~src_q);
    assign lim   = 3'((4'h1 << clk_cfg_r[i][scm_pkg::CK_DIV_LSB +: scm_pkg::CK_DIV_W]) - 4'h1);

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        clk_cfg_r[i] <= scm_pkg::RST_CLK_CFG;
      end else if (rif.wr_stb && rif.addr == scm_pkg::ADDR_CLK_BASE + 8'(i)) begin
        clk_cfg_r[i] <= rif.wdata;
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        src_q <= 1'b0;
        cnt_r <= 3'h0;
        ck_r[i] <= 1'b0;
      end else begin
        src_q <= src_s;
        if (!act[i]) begin
          cnt_r   <= 3'h0;
          ck_r[i] <= 1'b0;
        end else if (tick) begin
          if (cnt_r >= lim) begin
            cnt_r   <= 3'h0;
            ck_r[i] <= ~ck_r[i];
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
      end
    end
  end

  assign user_card_clock = ck_r[0];
  assign module_clock    = ck_r[NCH-1:1];

  // io muxes: channel 0 user pair, channels 1..3 module pairs
  localparam int MC_W = scm_pkg::MC_SEL_W;
  logic [MC_W-1:0] sel;
  logic [NCH-1:0] conn;
  logic [NCH-1:0] h_s;
  logic [NCH-1:0] c_s;
  logic [NCH-1:0] drv_card;
  logic [NCH-1:0] drv_host;
  assign sel = mod_ctrl_r[scm_pkg::MC_SEL_LSB +: MC_W];
  assign h_s = {{NMOD{hm_s}}, hu_s};
  assign c_s = {mio_s, ucio_s};

  for (genvar i = 0; i < NCH; i++) begin : g_io
    logic [2:0] hold_r;
    if (i == 0) begin : g_user
      assign conn[i] = user_act & slot_ctrl_r[scm_pkg::SC_IO_EN];
    end else begin : g_mod
      assign conn[i] = mod_act[i-1] & (sel == MC_W'(i));
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        drv_card[i] <= 1'b0;
        drv_host[i] <= 1'b0;
        hold_r      <= 3'h0;
      end else if (!conn[i]) begin
        drv_card[i] <= 1'b0;
        drv_host[i] <= 1'b0;
        hold_r      <= 3'h0;
      end else begin
        drv_card[i] <= ~h_s[i] & (drv_card[i] | (~drv_host[i] & hold_r == 3'h0));
        drv_host[i] <= ~c_s[i] & (drv_host[i] | (~drv_card[i] & hold_r == 3'h0 & h_s[i]));
        if ((drv_card[i] & h_s[i]) | (drv_host[i] & c_s[i])) begin
          hold_r <= scm_pkg::IO_HOLD;
        end else if (hold_r != 3'h0) begin
          hold_r <= hold_r - 3'h1;
        end
      end
    end
  end

  assign user_card_io_out     = 1'b0;
  assign user_card_io_oe_n    = ~drv_card[0];
  assign module_io_out        = '0;
  assign module_io_oe_n       = ~drv_card[NCH-1:1];
  assign host_io_user_out     = 1'b0;
  assign host_io_user_oe_n    = ~drv_host[0];
  assign host_io_modules_out  = 1'b0;
  assign host_io_modules_oe_n = ~|drv_host[NCH-1:1];
  assign aux_line_a_out       = 1'b0;
  assign aux_line_a_oe_n      = aux_a_oe_n_r;
  assign aux_line_b_out       = 1'b0;
  assign aux_line_b_oe_n      = aux_b_oe_n_r;

  // register reads
  always_comb begin
    rd = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (rif.addr == scm_pkg::ADDR_CLK_BASE + 8'(i)) begin
        rd = clk_cfg_r[i];
      end
    end
    case (rif.addr)
      scm_pkg::ADDR_SLOT_CTRL: rd = slot_ctrl_r;
      scm_pkg::ADDR_SYNC_SET: begin
        rd = sync_set_r;
        rd[scm_pkg::SS_AUX_A] = sync_set_r[scm_pkg::SS_AUX_A] & (aa_s | ~user_act);
        rd[scm_pkg::SS_AUX_B] = sync_set_r[scm_pkg::SS_AUX_B] & (ab_s | ~user_act);
      end
      scm_pkg::ADDR_MOD_CTRL: rd = mod_ctrl_r;
      scm_pkg::ADDR_STATUS: begin
        rd[scm_pkg::ST_CARD_PRESENCE_INPUT] = card_presence_input_s;
        rd[scm_pkg::ST_MODE_LSB +: 2] = mode_r;
      end
      scm_pkg::ADDR_DEV_SET:   rd = dev_set_r;
      scm_pkg::ADDR_GPIO_STAT: rd = {gflag_r, gpio_s};
      default: ;
    endcase
  end

  assign rif.rdata      = rd;
  assign slot_active    = act;
  assign mode           = mode_r;
  assign user_card_mode = uop_r;
endmodule

/* bench/scm_checker.sv */
// checker of scm_top mode, slot and idle pin relations
// assumes one clk domain and rstn async active low
`timescale 1ns/100ps
module scm_checker #(parameter int NMOD = 3) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rstn,
  // watched ports
  input wire logic          vdd_ok,
  input wire logic          vddi_ok,
  input wire logic          low_power_request_pin,
  input wire logic          sda_oe_n,
  input wire logic          aux_line_a_oe_n,
  input wire logic          aux_line_b_oe_n,
  input wire logic          user_card_clock,
  input wire logic [NMOD:0] slot_active,
  input scm_pkg::scm_mode_t mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_low_power_request_pin; mode == scm_pkg::SCM_SHUTDOWN [*2]; endsequence
  sequence s_idle; !slot_active[0] [*2]; endsequence
  a_off_supply: assert property (!(vdd_ok && vddi_ok) [*7] |-> mode == scm_pkg::SCM_OFF)
    else $error("mode not off");
  a_low_power_request_pin_pin: assert property ((vdd_ok && vddi_ok && !low_power_request_pin) [*7] |-> s_low_power_request_pin)
    else $error("mode not shutdown");
  a_stby_idle: assert property (mode == scm_pkg::SCM_STANDBY |-> $past(slot_active) == '0)
    else $error("standby with slot");
  a_act_slot: assert property (mode == scm_pkg::SCM_ACTIVE |-> $past(slot_active) != '0)
    else $error("active without slot");
  a_low_power_request_pin_clear: assert property (s_low_power_request_pin |-> slot_active == '0)
    else $error("slot kept in shutdown");
  a_low_power_request_pin_quiet: assert property (s_low_power_request_pin ##1 mode == scm_pkg::SCM_SHUTDOWN |-> sda_oe_n)
    else $error("sda driven in shutdown");
  a_aux_idle: assert property (s_idle |-> !aux_line_a_oe_n && !aux_line_b_oe_n)
    else $error("aux released while idle");
  a_uclk_idle: assert property (s_idle |-> !user_card_clock)
    else $error("user clock while idle");
endmodule
bind scm_top scm_checker #(.NMOD(NMOD)) scm_checker_inst (.*);

/* bench/scm_host.sv */
// host i2c master model, sda open drain with pull-up
// assumes target address 7'h2a
`timescale 1ns/100ps
module scm_host (
  // bus
  input  wire logic clk,
  input  wire logic sda_oe_n,
  output logic      scl = 1'h1,
  output wire logic sda_in
);
  logic sm = 1'h1;
  assign sda_in = sm & sda_oe_n;
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic bx(input logic b, output logic r);
    tk(3);
    sm <= b;
    tk(9);
    scl <= 1'h1;
    tk(12);
    r = sda_in;
    scl <= 1'h0;
  endtask
  task automatic cond(input logic a, input logic z);
    tk(3);
    sm <= a;
    tk(9);
    scl <= 1'h1;
    tk(12);
    sm <= z;
    tk(12);
    if (!z) scl <= 1'h0;
  endtask
  task automatic xb(input logic [7:0] v, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bx(v[i], r[i]);
    bx(1'h1, a);
  endtask
  task automatic txn(input logic rd, input logic [7:0] p, input logic [7:0] w, output logic [7:0] r,
                     output logic n);
    logic [7:0] t;
    logic a, b, c;
    cond(1'h1, 1'h0);
    xb({7'h2a, 1'h0}, t, a);
    xb(p, t, b);
    if (rd) cond(1'h1, 1'h0);
    xb(rd ? {7'h2a, 1'h1} : w, t, c);
    if (rd) xb(8'hff, r, t[0]);
    cond(1'h0, 1'h1);
    n = a | b | c;
  endtask
endmodule

/* bench/scm_top_test.sv */
// bench for scm_top: host model, pull-ups, queued checks
// assumes open-drain pins resolved here
`timescale 1ns/100ps
module scm_top_test;
  logic clk = 1'h0, rstn = 1'h0, vdd_ok = 1'h1, vddi_ok = 1'h1, low_power_request_pin = 1'h1;
  logic card_presence_input = 1'h1, host_io_user_in = 1'h1, xa = 1'h1, xm = 1'h1, n;
  logic user_clock_source = 1'h0, module_clock_source = 1'h0;
  logic [3:0] xg = 4'hf;
  logic [7:0] d, r, o, q[$];
  logic [7:0] ta[4] = '{8'h01, 8'h09, 8'h09, 8'h09};
  logic [7:0] tv[4] = '{8'h01, 8'h61, 8'he1, 8'h21};
  logic [1:0] ax[4] = '{2'h3, 2'h2, 2'h2, 2'h2};
  integer seed = 32'h8abc6d64, n_errors = 0, checks_done = 0;
  string s;
  event ev;
  scm_pkg::scm_uop_t user_card_mode;
  scm_pkg::scm_mode_t mode;
  wire scl, sda_in, sda_out, sda_oe_n, user_card_clock, user_card_io_in, user_card_io_out, user_card_io_oe_n;
  wire aux_line_a_in, aux_line_a_out, aux_line_a_oe_n, aux_line_b_in, aux_line_b_out, aux_line_b_oe_n, int_n;
  wire host_io_user_out, host_io_user_oe_n, host_io_modules_in, host_io_modules_out, host_io_modules_oe_n;
  wire [2:0] module_clock, module_io_in, module_io_out, module_io_oe_n;
  wire [3:0] gpio_in, gpio_out, gpio_oe_n, slot_active;
  assign aux_line_a_in = aux_line_a_oe_n & xa;
  assign aux_line_b_in = aux_line_b_oe_n;
  assign user_card_io_in = user_card_io_oe_n;
  assign module_io_in = module_io_oe_n;
  assign host_io_modules_in = host_io_modules_oe_n & xm;
  assign gpio_in = gpio_oe_n & xg;
  scm_top scm_top_inst (.*);
  scm_host scm_host_inst (.clk, .sda_oe_n, .scl, .sda_in);
  always #20 clk = ~clk;
  logic [2:0] cs = 3'h0;
  always @(posedge clk) cs <= cs + 3'h1;
  always @(posedge clk) {user_clock_source, module_clock_source} <= {2{cs[2]}};
  task automatic ts(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    q.push_back(e);
    s = nm;
    o = v;
    -> ev;
    @(negedge clk);
  endtask
  always @(ev) begin
    checks_done++;
    if (o !== q[0]) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, q[0], o);
    end
    void'(q.pop_front());
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    ts(12);
    chk("mode", {6'h0, scm_pkg::SCM_STANDBY}, {6'h0, mode});
    for (int i = 0; i < 4; i++) begin
      scm_host_inst.txn(1'h0, ta[i], tv[i], r, n);
      ts(10);
      chk("mode", {6'h0, scm_pkg::SCM_ACTIVE}, {6'h0, mode});
      chk("uop", 8'(i), {6'h0, user_card_mode});
      chk("aux", {6'h0, ax[i]}, {6'h0, aux_line_a_oe_n, aux_line_b_oe_n});
      r = {7'h0, user_card_clock};
      ts(8);
      chk("user clock", ~r & 8'h01, {7'h0, user_card_clock});
      @(posedge clk) xa <= 1'h0;
      scm_host_inst.txn(1'h1, 8'h09, 8'h00, d, n);
      chk("aux read", (i == 0 ? scm_pkg::RST_SYNC_SET : tv[i]) & 8'hdf, d);
      @(posedge clk) xa <= 1'h1;
      scm_host_inst.txn(1'h0, ta[i], tv[i] & 8'hfe, r, n);
      ts(10);
      chk("mode", {6'h0, scm_pkg::SCM_STANDBY}, {6'h0, mode});
      chk("aux idle", 8'h00, {6'h0, aux_line_a_oe_n, aux_line_b_oe_n});
    end
    d = 8'($random(seed));
    scm_host_inst.txn(1'h0, scm_pkg::ADDR_MOD_CTRL, {2'h0, 2'(d % 8'h3 + 8'h1), 4'h7}, r, n);
    @(posedge clk) xm <= 1'h0;
    ts(10);
    chk("slots", 8'h0e, {4'h0, slot_active});
    chk("module io", {5'h0, ~(3'h1 << (d % 8'h3))}, {5'h0, module_io_oe_n});
    r = {5'h0, module_clock};
    ts(8);
    chk("module clock", ~r & 8'h07, {5'h0, module_clock});
    @(posedge clk) low_power_request_pin <= 1'h0;
    xm <= 1'h1;
    ts(10);
    chk("mode", {6'h0, scm_pkg::SCM_SHUTDOWN}, {6'h0, mode});
    chk("slots", 8'h00, {4'h0, slot_active});
    @(posedge clk) xg[1] <= 1'h0;
    scm_host_inst.txn(1'h1, scm_pkg::ADDR_STATUS, 8'h00, d, n);
    chk("nak", 8'h01, {7'h0, n});
    @(posedge clk) low_power_request_pin <= 1'h1;
    ts(10);
    chk("mode", {6'h0, scm_pkg::SCM_STANDBY}, {6'h0, mode});
    chk("irq", 8'h01, {7'h0, int_n});
    @(posedge clk) xg[2] <= 1'h0;
    repeat (scm_pkg::GPIO_MIN_PULSE_CYC) @(posedge clk);
    xg[2] <= 1'h1;
    ts(10);
    chk("irq", 8'h00, {7'h0, int_n});
    d = 8'($random(seed));
    scm_host_inst.txn(1'h0, scm_pkg::ADDR_DEV_SET, {d[7:4], 4'h0}, r, n);
    ts(5);
    chk("gpio", {4'h0, d[7:4]}, {4'h0, gpio_oe_n});
    @(posedge clk) {vddi_ok, low_power_request_pin} <= 2'h0;
    ts(10);
    chk("mode", {6'h0, scm_pkg::SCM_OFF}, {6'h0, mode});
    report_and_stop;
  end
endmodule
